// File: shared/utx_pkg.sv
/*
  Constants and types for the serial transmit block: register addresses,
  field positions, reset values, parity codes and frame states.
  Assumes a byte-wide register port driven by the processor on the same clock.
*/
package utx_pkg;

  localparam logic [15:0] ADDR_MODE   = 16'hff50;
  localparam logic [15:0] ADDR_CTRL   = 16'hff51;
  localparam logic [15:0] ADDR_STATUS = 16'hff52;
  localparam logic [15:0] ADDR_BUF    = 16'hff53;

  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Mode register fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE   = 6;
  localparam int MODE_RXE   = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_LEN8  = 2;
  localparam int MODE_STOP2 = 1;

  // Control register fields
  localparam int CTRL_MSB_FIRST = 1;
  localparam int CTRL_INVERT    = 0;

  // Status register fields
  localparam int STAT_FULL = 1;
  localparam int STAT_BUSY = 0;

  // Parity select codes {hi, lo}
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [2:0] LAST_BIT7 = 3'h6;
  localparam logic [2:0] LAST_BIT8 = 3'h7;

  typedef enum logic [2:0] {
    UTX_IDLE,
    UTX_WAIT,
    UTX_START,
    UTX_DATA,
    UTX_PARITY,
    UTX_STOP
  } utx_state_t;

endpackage

// File: core/utx_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module utx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; occupancy is tracked by the counter
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule
`default_nettype wire

// File: core/utx_core.sv
/*
  Transmit side of an asynchronous serial channel with frame building,
  parity, bit order and polarity selection, a holding FIFO and status flags,
  plus the receive-side parity checker.
  Assumes a one-cycle baud_tick from an external baud generator on clk,
  and receiver logic on clk presenting characters to rx_check.
*/
//
// Contract
// - Frame: one start, seven or eight data, optional parity, one or two stops.
// - Four parity settings: even, odd, forced zero, none.
// - Bit order LSB or MSB first from control bit 1.
// - Output pin true or inverted from control bit 0.
// - Even parity: parity bit one when character has odd ones.
// - Even receive check: odd total ones gives parity error.
// - Odd parity: parity bit zero when character has odd ones.
// - Odd receive check: even total ones gives parity error.
// - Zero parity sends zero; receiver never flags an error.
// - No parity: no parity slot sent; receiver never flags.
// - Transmit enabled only when power set first, then enable.
// - Holding buffer write starts frame; framing bits added by hardware.
// - Frame start moves held character into shifter, shifted at baud rate.
// - Done pulse right after final stop bit has been driven.
// - With nothing waiting, stay idle until next write.
// - Buffer accepts next character once shifter started; frames back to back.
// - Status bit 1: holding buffer occupied, writing not permitted.
// - Status bit 0: transmission in progress.
// - Back-to-back flag pair walks 10, 11, 01; judge by bit 1.
// - Power off forces output high and internal receive input high; the pin is driven low instead when control bit 0 inverts.
`timescale 1ns/1ns
`default_nettype none
module utx_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        baud_tick,
  output logic             serial_output_pin,
  output logic             transmit_done_irq,
  input  wire logic        serial_input_pin,
  output logic             rx_internal,
  input  wire logic        rx_check,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_parity_bit,
  output logic             parity_error
);

  function automatic logic char_ones_odd(input logic [7:0] d, input logic len8);
    char_ones_odd = len8 ? (^d) : (^d[6:0]);
  endfunction

  function automatic logic tx_parity(input logic [7:0] d, input logic len8, input logic [1:0] sel);
    case (sel)
      utx_pkg::PAR_EVEN: tx_parity = char_ones_odd(d, len8);
      utx_pkg::PAR_ODD:  tx_parity = !char_ones_odd(d, len8);
      default:           tx_parity = 1'b0;
    endcase
  endfunction

  function automatic logic data_bit(input logic [7:0] d, input logic [2:0] idx,
                                    input logic [2:0] last, input logic msb_first);
    data_bit = msb_first ? d[3'(last - idx)] : d[idx];
  endfunction

  // Register group
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       tx_on_q;
  logic       tx_on_d;
  logic [7:0] reg_rdata_d;

  // Shifter group
  utx_pkg::utx_state_t state_q;
  utx_pkg::utx_state_t state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       par_q;
  logic       par_d;
  logic       line_q;
  logic       line_d;
  logic       pin_d;
  logic       done_d;
  logic       pop;

  // Receive-side group
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_int_d;
  logic perr_d;

  logic       fifo_in_valid;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  logic [1:0] psel;
  logic       len8;
  logic [2:0] last_bit;
  logic       holding_full_flag;
  logic       shifter_busy_flag;

  assign psel              = {mode_q[utx_pkg::MODE_PS_HI], mode_q[utx_pkg::MODE_PS_LO]};
  assign len8              = mode_q[utx_pkg::MODE_LEN8];
  assign last_bit          = len8 ? utx_pkg::LAST_BIT8 : utx_pkg::LAST_BIT7;
  assign holding_full_flag = fifo_out_valid;
  assign shifter_busy_flag = (state_q != utx_pkg::UTX_IDLE);
  assign fifo_in_valid     = reg_wr && (reg_addr == utx_pkg::ADDR_BUF) && tx_on_q;

  // Pending characters wait here; a write while full is dropped, matching
  // the undefined outcome software must avoid by polling the full flag
  utx_fifo #(
    .WIDTH (utx_pkg::FIFO_WIDTH),
    .DEPTH (utx_pkg::FIFO_DEPTH)
  ) u_hold (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (!tx_on_q),
    .in_valid  (fifo_in_valid),
    .in_ready  (),
    .in_data   (reg_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    mode_d  = mode_q;
    ctrl_d  = ctrl_q;
    tx_on_d = tx_on_q;
    if (reg_wr && (reg_addr == utx_pkg::ADDR_MODE)) begin
      mode_d  = reg_wdata;
      // Enable needs power already on before this write, or already running
      tx_on_d = reg_wdata[utx_pkg::MODE_POWER] && reg_wdata[utx_pkg::MODE_TXE] &&
                (tx_on_q || mode_q[utx_pkg::MODE_POWER]);
    end
    if (reg_wr && (reg_addr == utx_pkg::ADDR_CTRL)) begin
      ctrl_d = reg_wdata;
    end
    case (reg_addr)
      utx_pkg::ADDR_MODE:   reg_rdata_d = mode_q;
      utx_pkg::ADDR_CTRL:   reg_rdata_d = ctrl_q;
      utx_pkg::ADDR_STATUS: reg_rdata_d = {6'h00, holding_full_flag, shifter_busy_flag};
      default:              reg_rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q    <= utx_pkg::MODE_RST;
      ctrl_q    <= utx_pkg::CTRL_RST;
      tx_on_q   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      mode_q    <= mode_d;
      ctrl_q    <= ctrl_d;
      tx_on_q   <= tx_on_d;
      reg_rdata <= reg_rdata_d;
    end
  end

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    par_d   = par_q;
    line_d  = line_q;
    done_d  = 1'b0;
    pop     = 1'b0;
    if (!tx_on_q) begin
      state_d = utx_pkg::UTX_IDLE;
      line_d  = 1'b1;
    end else begin
      case (state_q)
        utx_pkg::UTX_IDLE: begin
          line_d = 1'b1;
          if (fifo_out_valid) begin
            pop     = 1'b1;
            shift_d = fifo_out_data;
            par_d   = tx_parity(fifo_out_data, len8, psel);
            state_d = utx_pkg::UTX_WAIT;
          end
        end
        utx_pkg::UTX_WAIT: begin
          if (baud_tick) begin
            line_d  = 1'b0;
            state_d = utx_pkg::UTX_START;
          end
        end
        utx_pkg::UTX_START: begin
          if (baud_tick) begin
            cnt_d   = 3'h0;
            line_d  = data_bit(shift_q, 3'h0, last_bit, ctrl_q[utx_pkg::CTRL_MSB_FIRST]);
            state_d = utx_pkg::UTX_DATA;
          end
        end
        utx_pkg::UTX_DATA: begin
          if (baud_tick) begin
            if (cnt_q == last_bit) begin
              cnt_d = 3'h0;
              if (psel == utx_pkg::PAR_NONE) begin
                line_d  = 1'b1;
                state_d = utx_pkg::UTX_STOP;
              end else begin
                line_d  = par_q;
                state_d = utx_pkg::UTX_PARITY;
              end
            end else begin
              cnt_d  = 3'(cnt_q + 1'b1);
              line_d = data_bit(shift_q, 3'(cnt_q + 1'b1), last_bit, ctrl_q[utx_pkg::CTRL_MSB_FIRST]);
            end
          end
        end
        utx_pkg::UTX_PARITY: begin
          if (baud_tick) begin
            line_d  = 1'b1;
            cnt_d   = 3'h0;
            state_d = utx_pkg::UTX_STOP;
          end
        end
        utx_pkg::UTX_STOP: begin
          if (baud_tick) begin
            if (cnt_q == {2'h0, mode_q[utx_pkg::MODE_STOP2]}) begin
              done_d = 1'b1;
              // Chain straight into the next start bit so frames run back to back
              if (fifo_out_valid) begin
                pop     = 1'b1;
                shift_d = fifo_out_data;
                par_d   = tx_parity(fifo_out_data, len8, psel);
                line_d  = 1'b0;
                state_d = utx_pkg::UTX_START;
              end else begin
                state_d = utx_pkg::UTX_IDLE;
              end
            end else begin
              cnt_d = 3'(cnt_q + 1'b1);
            end
          end
        end
        default: begin
          state_d = utx_pkg::UTX_IDLE;
          line_d  = 1'b1;
        end
      endcase
    end
    pin_d = line_d ^ ctrl_d[utx_pkg::CTRL_INVERT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q           <= utx_pkg::UTX_IDLE;
      shift_q           <= 8'h00;
      cnt_q             <= 3'h0;
      par_q             <= 1'b0;
      line_q            <= 1'b1;
      serial_output_pin <= 1'b1;
      transmit_done_irq <= 1'b0;
    end else begin
      state_q           <= state_d;
      shift_q           <= shift_d;
      cnt_q             <= cnt_d;
      par_q             <= par_d;
      line_q            <= line_d;
      serial_output_pin <= pin_d;
      transmit_done_irq <= done_d;
    end
  end

  always_comb begin
    rx_int_d = mode_q[utx_pkg::MODE_POWER] ? rx_s2_q : 1'b1;
    perr_d   = parity_error;
    if (rx_check) begin
      case (psel)
        utx_pkg::PAR_EVEN: perr_d = char_ones_odd(rx_char, len8) ^ rx_parity_bit;
        utx_pkg::PAR_ODD:  perr_d = !(char_ones_odd(rx_char, len8) ^ rx_parity_bit);
        default:           perr_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_s1_q      <= 1'b1;
      rx_s2_q      <= 1'b1;
      rx_internal  <= 1'b1;
      parity_error <= 1'b0;
    end else begin
      rx_s1_q      <= serial_input_pin;
      rx_s2_q      <= rx_s1_q;
      rx_internal  <= rx_int_d;
      parity_error <= perr_d;
    end
  end

  a_done_after_stop: assert property (@(posedge clk) disable iff (!rst_n)
    transmit_done_irq |-> $past(state_q) == utx_pkg::UTX_STOP && $past(baud_tick))
    else $error("done pulse not right after final stop");
  a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == utx_pkg::UTX_START) |-> !line_q)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == utx_pkg::UTX_STOP) |-> line_q)
    else $error("stop bit not high");
  a_idle_pin_level: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == utx_pkg::UTX_IDLE) && $past(state_q == utx_pkg::UTX_IDLE) && $stable(ctrl_q)
      |-> serial_output_pin == !ctrl_q[utx_pkg::CTRL_INVERT])
    else $error("idle pin level wrong");
  a_enable_order: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tx_on_q) |-> $past(mode_q[utx_pkg::MODE_POWER]) && mode_q[utx_pkg::MODE_TXE])
    else $error("enabled without prior power");
  a_no_parity_slot: assert property (@(posedge clk) disable iff (!rst_n)
    (psel == utx_pkg::PAR_NONE) && $stable(mode_q) |-> state_q != utx_pkg::UTX_PARITY)
    else $error("parity slot sent with no parity");
  a_zero_parity_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == utx_pkg::UTX_PARITY) && (psel == utx_pkg::PAR_ZERO) && $stable(mode_q) |-> !line_q)
    else $error("zero parity bit not zero");
  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_addr == utx_pkg::ADDR_STATUS) |=> reg_rdata == {6'h00, $past(holding_full_flag), $past(shifter_busy_flag)})
    else $error("status read mismatch");
  a_pop_to_busy: assert property (@(posedge clk) disable iff (!rst_n)
    pop && tx_on_q |=> shifter_busy_flag || !tx_on_q)
    else $error("loaded character without busy shifter");
  a_rx_no_check: assert property (@(posedge clk) disable iff (!rst_n)
    rx_check && (psel == utx_pkg::PAR_ZERO || psel == utx_pkg::PAR_NONE) |=> !parity_error)
    else $error("parity error flagged without checking");

endmodule
`default_nettype wire

// File: bench/utx_peer.sv
/*
  Far-end serial receiver: frames the line two cycles after each baud tick.
  Assumes the shared baud tick and that the bench says how many bits follow the start.
*/
`timescale 1ns/1ns
`default_nettype none
module utx_peer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       baud_tick,
  input  wire logic       line,
  input  wire logic       invert,
  input  wire logic       listen,
  input  wire logic       rx_level,
  input  wire logic [3:0] nbits,
  output logic            serial_input_pin,
  output logic      [11:0] frame,
  output logic      [7:0]  nframes
);
  logic [1:0] tick_d;
  logic [3:0] idx;
  logic       busy;
  logic       bit_v;

  // Undo the output inversion so framing is judged on true levels
  assign bit_v = line ^ invert;
  assign serial_input_pin = rx_level;

  // Sample two cycles after the tick, well inside the bit
  always @(posedge clk) begin
    tick_d <= {tick_d[0], baud_tick};
    if (!rst_n) begin
      busy <= 1'h0;
      idx <= 4'h0;
      nframes <= 8'h00;
    end else if (!listen) begin
      busy <= 1'h0;
    end else if (tick_d[1]) begin
      if (!busy) begin
        busy <= !bit_v;
        idx <= 4'h0;
      end else begin
        frame[idx] <= bit_v;
        idx <= idx + 4'h1;
        if (idx == nbits - 4'h1) begin
          busy <= 1'h0;
          nframes <= nframes + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/utx_core_tb.sv
/*
  Self-checking bench for the serial transmit block: registers, frames, flags, parity check.
  Assumes the far-end receiver model and a baud tick every eight clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module utx_core_tb;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        reg_wr = 1'h0;
  logic        baud_tick = 1'h0;
  logic        rx_check = 1'h0;
  logic        rx_pbit = 1'h0;
  logic        rx_level = 1'h1;
  logic        inv = 1'h0;
  logic        listen = 1'h0;
  logic [15:0] reg_addr = utx_pkg::ADDR_STATUS;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  rx_char = 8'h00;
  logic [3:0]  nbits = 4'h9;
  logic [2:0]  bcnt = 3'h0;
  logic [7:0]  reg_rdata;
  logic        pin;
  logic        done;
  logic        rx_int;
  logic        perr;
  logic        sin;
  logic [11:0] frame;
  logic [7:0]  nfr;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_done = 0;
  int          nexp = 0;

  utx_core dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .baud_tick(baud_tick), .serial_output_pin(pin), .transmit_done_irq(done),
    .serial_input_pin(sin), .rx_internal(rx_int), .rx_check(rx_check), .rx_char(rx_char),
    .rx_parity_bit(rx_pbit), .parity_error(perr));
  utx_peer peer (.clk(clk), .rst_n(rst_n), .baud_tick(baud_tick), .line(pin), .invert(inv), .listen(listen),
    .rx_level(rx_level), .nbits(nbits), .serial_input_pin(sin), .frame(frame), .nframes(nfr));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    bcnt <= bcnt + 3'h1;
    baud_tick <= (bcnt == 3'h7);
    if (done === 1'h1) n_done++;
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({11'h000, got}, {11'h000, exp});
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_val({4'h0, reg_rdata}, {4'h0, e});
  endtask

  function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic [7:0] m, input logic msb,
                                            output int n);
    logic [11:0] f;
    logic        p;
    int          nd;
    f = 12'h000;
    nd = m[utx_pkg::MODE_LEN8] ? 8 : 7;
    p = ^(d & (m[utx_pkg::MODE_LEN8] ? 8'hff : 8'h7f));
    n = 0;
    for (int i = 0; i < nd; i++) begin
      f[n] = msb ? d[nd - 1 - i] : d[i];
      n++;
    end
    if (m[4:3] != utx_pkg::PAR_NONE) begin
      f[n] = (m[4:3] == utx_pkg::PAR_EVEN) ? p : ((m[4:3] == utx_pkg::PAR_ODD) ? ~p : 1'h0);
      n++;
    end
    f[n] = 1'h1;
    f[n + 1] = m[utx_pkg::MODE_STOP2];
    n = n + (m[utx_pkg::MODE_STOP2] ? 2 : 1);
    return f;
  endfunction

  // Power first, then enable: a combined write from off must not enable
  task automatic setup(input logic [7:0] m, input logic [7:0] c);
    logic [11:0] f;
    int          n;
    listen <= 1'h0;
    wr(utx_pkg::ADDR_MODE, 8'h80);
    wr(utx_pkg::ADDR_CTRL, c);
    wr(utx_pkg::ADDR_MODE, m | 8'hc0);
    repeat (4) @(posedge clk);
    f = exp_frame(8'h00, m, 1'h0, n);
    inv <= c[utx_pkg::CTRL_INVERT];
    nbits <= n[3:0];
    listen <= 1'h1;
  endtask

  task automatic get_frame(input logic [7:0] d, input logic [7:0] m, input logic [7:0] c);
    logic [11:0] f;
    int          n;
    int          k;
    f = exp_frame(d, m, c[utx_pkg::CTRL_MSB_FIRST], n);
    nexp++;
    k = 0;
    while (nfr != nexp[7:0] && k < 300) begin
      @(negedge clk);
      k++;
    end
    // A frame that never arrives fails here rather than passing on stale data
    chk_val({4'h0, nfr}, nexp[11:0]);
    chk_val(frame & ((12'h001 << n) - 12'h001), f);
    chk_val(n_done[11:0], nexp[11:0] - 12'h001);
    k = 0;
    while (n_done != nexp && k < 12) begin
      @(negedge clk);
      k++;
    end
    chk_val(n_done[11:0], nexp[11:0]);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  logic [23:0] ftab [8] = '{24'h1c0055, 24'h1c0255, 24'h1c0355, 24'h120036,
                            24'h040087, 24'h0e00ff, 24'h1802db, 24'h1401a7};
  logic [11:0] ptab [6] = '{{2'h3, 8'h01, 1'h1, 1'h0}, {2'h3, 8'h01, 1'h0, 1'h1}, {2'h1, 8'h01, 1'h0, 1'h0},
                            {2'h2, 8'h01, 1'h0, 1'h0}, {2'h2, 8'h03, 1'h0, 1'h1}, {2'h0, 8'h01, 1'h0, 1'h0}};

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report;
  end

  initial begin
    logic [7:0] m;
    logic [7:0] c;
    logic [7:0] d;
    int         k;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(utx_pkg::ADDR_MODE, utx_pkg::MODE_RST);
    rd(utx_pkg::ADDR_CTRL, utx_pkg::CTRL_RST);
    rd(utx_pkg::ADDR_STATUS, 8'h00);
    rd(utx_pkg::ADDR_BUF, 8'h00);
    rd(16'hff54, 8'h00);
    chk_bit(pin, 1'h1);
    chk_bit(perr, 1'h0);
    tend("reset");
    wr(utx_pkg::ADDR_MODE, 8'hc0);
    wr(utx_pkg::ADDR_BUF, 8'h11);
    rd(utx_pkg::ADDR_STATUS, 8'h00);
    tend("enable order");
    for (int i = 0; i < 8; i++) begin
      {m, c, d} = ftab[i];
      setup(m, c);
      wr(utx_pkg::ADDR_BUF, d);
      get_frame(d, m, c);
    end
    tend("frames");
    setup(8'h04, 8'h00);
    wr(utx_pkg::ADDR_BUF, 8'ha1);
    rd(utx_pkg::ADDR_STATUS, 8'h01);
    wr(utx_pkg::ADDR_BUF, 8'ha2);
    rd(utx_pkg::ADDR_STATUS, 8'h03);
    get_frame(8'ha1, 8'h04, 8'h00);
    get_frame(8'ha2, 8'h04, 8'h00);
    rd(utx_pkg::ADDR_STATUS, 8'h00);
    for (int i = 0; i < 12; i++) wr(utx_pkg::ADDR_BUF, 8'hb0 + i[7:0]);
    rd(utx_pkg::ADDR_STATUS, 8'h03);
    for (int i = 0; i < 9; i++) get_frame(8'hb0 + i[7:0], 8'h04, 8'h00);
    rd(utx_pkg::ADDR_STATUS, 8'h00);
    repeat (200) @(negedge clk);
    chk_val({4'h0, nfr}, nexp[11:0]);
    tend("back to back and fill");
    for (int i = 0; i < 6; i++) begin
      wr(utx_pkg::ADDR_MODE, 8'h84 | {3'h0, ptab[i][11:10], 3'h0});
      @(posedge clk);
      rx_check <= 1'h1;
      rx_char <= ptab[i][9:2];
      rx_pbit <= ptab[i][1];
      @(posedge clk);
      rx_check <= 1'h0;
      @(negedge clk);
      chk_bit(perr, ptab[i][0]);
    end
    tend("parity check");
    setup(8'h04, 8'h00);
    rx_level <= 1'h0;
    wr(utx_pkg::ADDR_BUF, 8'h00);
    k = 0;
    while (pin !== 1'h0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    // A start bit that never shows fails here instead of slipping through
    chk_bit(pin, 1'h0);
    chk_bit(rx_int, 1'h0);
    wr(utx_pkg::ADDR_MODE, 8'h00);
    repeat (2) @(negedge clk);
    chk_bit(pin, 1'h1);
    chk_bit(rx_int, 1'h1);
    rd(utx_pkg::ADDR_STATUS, 8'h00);
    tend("power off");
    final_report;
  end
endmodule
`default_nettype wire
